// *** core/uart_mctl.sv ***
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module uart_mctl #(
  parameter bit MODEM_EN = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   ce_i,
  // AHB-Lite slave
  input  wire logic                   hsel_i,
  input  wire logic [11:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  // Serial core side
  input  wire logic                   tx_serial_i,
  input  wire logic                   tx_active_i,
  input  wire logic [3:0]             rx_count_i,
  input  wire uart_mctl_pkg::irq_src_s src_i,
  input  wire logic                   msr_clear_i,
  output logic                        rx_serial_o,
  output logic                        tx_start_ok_o,
  output uart_mctl_pkg::modem_st_s    modem_o,
  output logic                        modem_chg_o,
  output logic [3:0]                  trig_level_o,
  output logic                        soft_reset_o,
  output logic                        irq_o,
  // Pins
  input  wire logic                   rxd_i,
  input  wire logic                   cts_n_i,
  input  wire logic                   dsr_n_i,
  input  wire logic                   ri_n_i,
  input  wire logic                   dcd_n_i,
  output logic                        txd_o,
  output logic                        txd_oe_n_o,
  output logic                        rts_n_o,
  output logic                        rts_oe_n_o,
  output logic                        dtr_n_o,
  output logic                        dtr_oe_n_o
);
  import uart_mctl_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]  mc_q;
  logic [7:0]  ie_q;
  logic [1:0]  trig_sel_q;
  logic        srst_pulse_q;
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic        hit_q;
  logic [1:0]  idx_q;
  logic        ready_q;
  logic [31:0] rdata_q;
  logic        rts_hold_q;
  logic        delta_q;
  modem_st_s   m_q;
  logic        tx_ok_q;
  logic [3:0]  trig_q;
  logic        irq_q;
  logic        rx_q;
  logic        txd_q;
  logic        txd_oe_n_q;
  logic        rts_n_q;
  logic        rts_oe_n_q;
  logic        dtr_n_q;
  logic        dtr_oe_n_q;

  logic        addr_ph;
  logic        we;
  logic [7:0]  mc_wmask;
  logic [7:0]  ie_wmask;
  logic [7:0]  rd_mux;
  logic [3:0]  trig_d;
  logic        loop;
  logic        auto_fc;
  logic        rts_act;
  logic        chg;
  modem_st_s   m_d;

  // ****************************************
  // Bus slave
  // ****************************************
  assign addr_ph = hsel_i & htrans_i[1] & hready_i;
  assign we      = wr_pend_q & hit_q;

  // Only whole-word transfers are expected; hsize is not checked
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hit_q     <= 1'b0;
      idx_q     <= 2'h0;
      ready_q   <= 1'b1;
      rdata_q   <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wr_pend_q <= addr_ph & hwrite_i;
      rd_pend_q <= addr_ph & ~hwrite_i;
      // A read costs one wait state so a write just before it is seen
      ready_q   <= ~(addr_ph & ~hwrite_i);
      if (addr_ph)
      begin
        idx_q <= haddr_i[3:2];
        hit_q <= (haddr_i[11:4] == 8'h00) && (haddr_i[1:0] == 2'h0);
      end
      if (rd_pend_q)
      begin
        rdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_q)
    begin
      unique case (idx_q)
        IDX_MODEM_CTRL: rd_mux = mc_q;
        IDX_INT_ENABLE: rd_mux = ie_q;
        IDX_TRIGGER:    rd_mux = {trig_sel_q, 6'h00};
        IDX_STATUS:     rd_mux = {delta_q, tx_ok_q, m_q.dcd, m_q.ri,
                                  m_q.dsr, m_q.cts, ~dtr_n_q, ~rts_n_q};
      endcase
    end
  end

  assign hrdata_o    = rdata_q;
  assign hreadyout_o = ready_q;
  assign hresp_o     = 1'b0;

  // ****************************************
  // Control registers
  // ****************************************
  // Modem bits cannot be stored on a port without modem support
  assign mc_wmask = MODEM_EN ? 8'hFF : ~MC_MODEM_BITS;
  assign ie_wmask = IE_STORE_BITS &
                    (MODEM_EN ? 8'hFF : ~IE_MODEM_BITS);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mc_q       <= MODEM_CTRL_RST;
      ie_q       <= INT_ENABLE_RST;
      trig_sel_q <= TRIG_SEL_RST;
    end
    else if (ce_i)
    begin
      if (srst_pulse_q)
      begin
        mc_q       <= MODEM_CTRL_RST;
        ie_q       <= INT_ENABLE_RST;
        trig_sel_q <= TRIG_SEL_RST;
      end
      else if (we)
      begin
        if (idx_q == IDX_MODEM_CTRL)
        begin
          mc_q <= hwdata_i[7:0] & mc_wmask;
        end
        if (idx_q == IDX_INT_ENABLE)
        begin
          // Reset bit is never stored so it reads back as zero
          ie_q <= hwdata_i[7:0] & ie_wmask;
        end
        if (idx_q == IDX_TRIGGER)
        begin
          trig_sel_q <= hwdata_i[TRIG_POS+1:TRIG_POS];
        end
      end
    end
  end

  // Soft reset pulse lasts one cycle, clearing itself
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      srst_pulse_q <= 1'b0;
    end
    else if (ce_i)
    begin
      srst_pulse_q <= we && (idx_q == IDX_INT_ENABLE) &&
                      hwdata_i[IE_SRST_POS];
    end
  end

  assign soft_reset_o = srst_pulse_q;

  // ****************************************
  // Trigger point
  // ****************************************
  always_comb
  begin
    trig_d = TRIG_BYTES_0;
    unique case (trig_sel_q)
      2'h0: trig_d = TRIG_BYTES_0;
      2'h1: trig_d = TRIG_BYTES_1;
      2'h2: trig_d = TRIG_BYTES_2;
      2'h3: trig_d = TRIG_BYTES_3;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      trig_q <= TRIG_BYTES_0;
    end
    else if (ce_i)
    begin
      trig_q <= trig_d;
    end
  end

  assign trig_level_o = trig_q;

  // ****************************************
  // Modem signals
  // ****************************************
  assign loop    = mc_q[MC_LOOP_POS];
  assign auto_fc = mc_q[MC_AUTO_POS];
  assign rts_act = mc_q[MC_RTS_POS] &
                   ~(auto_fc & rts_hold_q);

  always_comb
  begin
    m_d = '0;
    if (MODEM_EN && loop)
    begin
      m_d.cts = rts_act;
      m_d.dsr = mc_q[MC_DTR_POS];
      m_d.ri  = mc_q[MC_USER_POS];
      m_d.dcd = mc_q[MC_GATE_POS];
    end
    else if (MODEM_EN)
    begin
      m_d.cts = ~cts_n_i;
      m_d.dsr = ~dsr_n_i;
      m_d.ri  = ~ri_n_i;
      m_d.dcd = ~dcd_n_i;
    end
  end

  // Ring counts on its trailing edge only, as in the classic part
  assign chg = ((m_d.cts ^ m_q.cts) & ~auto_fc) |
               (m_d.dsr ^ m_q.dsr) |
               (m_q.ri & ~m_d.ri) |
               (m_d.dcd ^ m_q.dcd);

  // A change in the clearing cycle still sets the flag
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      m_q     <= '0;
      delta_q <= 1'b0;
    end
    else if (ce_i)
    begin
      m_q <= m_d;
      if (srst_pulse_q)
      begin
        delta_q <= 1'b0;
      end
      else
      begin
        delta_q <= chg | (delta_q & ~msr_clear_i);
      end
    end
  end

  assign modem_o     = m_q;
  assign modem_chg_o = delta_q;

  // ****************************************
  // Automatic flow control
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rts_hold_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (srst_pulse_q || rx_count_i == 4'h0)
      begin
        rts_hold_q <= 1'b0;
      end
      else if (rx_count_i >= trig_q)
      begin
        rts_hold_q <= 1'b1;
      end
    end
  end

  // Checked before each character; one in flight is not cut off
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      tx_ok_q <= 1'b1;
    end
    else if (ce_i)
    begin
      tx_ok_q <= ~auto_fc | m_d.cts;
    end
  end

  assign tx_start_ok_o = tx_ok_q;

  // ****************************************
  // Interrupt request
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      irq_q <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_q <= mc_q[MC_GATE_POS] &
               ((ie_q[3] & delta_q) |
                (ie_q[2] & src_i.line_stat) |
                (ie_q[1] & src_i.thr_empty) |
                (ie_q[0] & src_i.rx_data));
    end
  end

  assign irq_o = irq_q;

  // ****************************************
  // Receive path
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rx_q <= 1'b1;
    end
    else if (ce_i)
    begin
      if (loop)
      begin
        rx_q <= tx_serial_i;
      end
      else if (mc_q[MC_HALF_POS] && tx_active_i)
      begin
        // Idle level hides our own echo on a shared line
        rx_q <= 1'b1;
      end
      else
      begin
        rx_q <= rxd_i;
      end
    end
  end

  assign rx_serial_o = rx_q;

  // ****************************************
  // Output pins
  // ****************************************
  // In loopback the pins idle high and their drivers are released
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      txd_q      <= 1'b1;
      txd_oe_n_q <= 1'b1;
      rts_n_q    <= 1'b1;
      rts_oe_n_q <= 1'b1;
      dtr_n_q    <= 1'b1;
      dtr_oe_n_q <= 1'b1;
    end
    else if (ce_i)
    begin
      txd_q      <= loop | tx_serial_i;
      txd_oe_n_q <= ~(ie_q[IE_TXD_POS] & ~loop);
      rts_n_q    <= loop | ~rts_act;
      rts_oe_n_q <= ~(ie_q[IE_RTS_POS] & ~loop);
      dtr_oe_n_q <= ~(ie_q[IE_DTR_POS] & ~loop);
      if (loop)
      begin
        dtr_n_q <= 1'b1;
      end
      else if (mc_q[MC_TXIND_POS])
      begin
        // High while sending, to key an RS485 driver
        dtr_n_q <= tx_active_i;
      end
      else
      begin
        dtr_n_q <= ~mc_q[MC_DTR_POS];
      end
    end
  end

  assign txd_o      = txd_q;
  assign txd_oe_n_o = txd_oe_n_q;
  assign rts_n_o    = rts_n_q;
  assign rts_oe_n_o = rts_oe_n_q;
  assign dtr_n_o    = dtr_n_q;
  assign dtr_oe_n_o = dtr_oe_n_q;

endmodule : uart_mctl

// *** core/uart_mctl_pkg.sv ***
// Behaviour
// - Half-duplex: transmit first, receive only when idle
// - Indication on DTR shows transmission in progress
// - Auto flow: next character only with CTS
// - Auto flow: CTS change raises no modem interrupt
// - Auto flow with RTS bit: RTS active when empty
// - RTS drops at trigger, returns when FIFO empties
// - Loopback makes all serial output pins inactive
// - Loopback routes TX, RTS, DTR, user flags back
// - Request gate bit passes or blocks the interrupt
// - User modem flag is stored, no pin
// - RTS level bit set drives RTS low
// - DTR level bit set drives DTR low
// - Soft reset bit resets UART, clears itself
// - TXD driver enabled by its enable bit
// - RTS and DTR drivers have own enables
// - Modem change interrupt needs its enable
// - Line status interrupt needs its enable
// - Holding empty interrupt needs its enable
// - Receive data interrupt needs its enable
// - Trigger point selects 1, 2, 4 or 7
package uart_mctl_pkg;

  // ****************************************
  // Register map (index, byte address = 4x)
  // ****************************************
  localparam logic [1:0]  IDX_MODEM_CTRL = 2'h0;
  localparam logic [1:0]  IDX_INT_ENABLE = 2'h1;
  localparam logic [1:0]  IDX_TRIGGER    = 2'h2;
  localparam logic [1:0]  IDX_STATUS     = 2'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MC_HALF_POS   = 7;
  localparam int MC_TXIND_POS  = 6;
  localparam int MC_AUTO_POS   = 5;
  localparam int MC_LOOP_POS   = 4;
  localparam int MC_GATE_POS   = 3;
  localparam int MC_USER_POS   = 2;
  localparam int MC_RTS_POS    = 1;
  localparam int MC_DTR_POS    = 0;
  localparam int IE_SRST_POS   = 7;
  localparam int IE_TXD_POS    = 6;
  localparam int IE_RTS_POS    = 5;
  localparam int IE_DTR_POS    = 4;
  localparam int TRIG_POS      = 6;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0]  MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0]  INT_ENABLE_RST = 8'h00;
  localparam logic [1:0]  TRIG_SEL_RST   = 2'h0;
  localparam logic [7:0]  MC_MODEM_BITS  = 8'hF7;
  localparam logic [7:0]  IE_MODEM_BITS  = 8'h38;
  localparam logic [7:0]  IE_STORE_BITS  = 8'h7F;

  // Trigger points in bytes
  localparam logic [3:0]  TRIG_BYTES_0 = 4'h1;
  localparam logic [3:0]  TRIG_BYTES_1 = 4'h2;
  localparam logic [3:0]  TRIG_BYTES_2 = 4'h4;
  localparam logic [3:0]  TRIG_BYTES_3 = 4'h7;

  // Modem inputs, active high after the pin inversion
  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic dcd;
  } modem_st_s;

  // Interrupt sources from the serial core
  typedef struct packed {
    logic line_stat;
    logic thr_empty;
    logic rx_data;
  } irq_src_s;

endpackage : uart_mctl_pkg

// *** tb/uart_mctl_assertions.sv ***
`timescale 1ns/100ps
module uart_mctl_assertions (
  // Clock, reset, enable
  input wire logic                     clk_i,
  input wire logic                     srst_i,
  input wire logic                     ce_i,
  // Bus
  input wire logic                     hsel_i,
  input wire logic [1:0]               htrans_i,
  input wire logic                     hwrite_i,
  input wire logic                     hready_i,
  input wire logic [31:0]              hrdata_o,
  input wire logic                     hreadyout_o,
  input wire logic                     hresp_o,
  // Core side
  input wire logic                     tx_serial_i,
  input wire logic                     soft_reset_o,
  input wire logic                     irq_o,
  input wire logic [3:0]               trig_level_o,
  input wire uart_mctl_pkg::modem_st_s modem_o,
  // Pins
  input wire logic                     txd_o,
  input wire logic                     txd_oe_n_o,
  input wire logic                     rts_n_o,
  input wire logic                     rts_oe_n_o,
  input wire logic                     dtr_n_o,
  input wire logic                     dtr_oe_n_o
);
  import uart_mctl_pkg::*;
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic rd_tk;
  logic wr_tk;
  assign rd_tk = hsel_i & htrans_i[1] & hready_i & ce_i & ~hwrite_i;
  assign wr_tk = hsel_i & htrans_i[1] & hready_i & ce_i & hwrite_i;
  property p_okay; hresp_o == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  property p_rd_wait; rd_tk |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast; wr_tk |=> hreadyout_o; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_rd_hold; $changed(hrdata_o) |-> !$past(hreadyout_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_sr_pulse; soft_reset_o |=> !soft_reset_o; endproperty
  a_sr_pulse: assert property (p_sr_pulse) else $error("long pulse");
  property p_sr_clear;
    soft_reset_o |=> ##1 (txd_oe_n_o && rts_oe_n_o && dtr_oe_n_o
      && !irq_o && trig_level_o == 4'h1 && rts_n_o && dtr_n_o);
  endproperty
  a_sr_clear: assert property (p_sr_clear) else $error("no clear");
  property p_trig; trig_level_o inside {4'h1, 4'h2, 4'h4, 4'h7}; endproperty
  a_trig: assert property (p_trig) else $error("bad trigger");
  // Loopback releases the driver, so a driven TXD always follows the core
  property p_txd;
    !txd_oe_n_o && $past(ce_i) |-> txd_o == $past(tx_serial_i);
  endproperty
  a_txd: assert property (p_txd) else $error("txd not core");
  property p_rls;
    $fell(srst_i) |-> txd_oe_n_o && rts_oe_n_o && dtr_oe_n_o && !irq_o
      && hreadyout_o && trig_level_o == 4'h1 && modem_o == 4'h0;
  endproperty
  a_rls: assert property (p_rls) else $error("reset values");
  property p_freeze;
    !ce_i |=> $stable({txd_o, rts_n_o, dtr_n_o, irq_o, modem_o});
  endproperty
  a_freeze: assert property (p_freeze) else $error("moved when frozen");
  c_sr: cover property (soft_reset_o);
  c_rd: cover property (rd_tk ##1 !hreadyout_o);
  c_irq: cover property ($rose(irq_o));
endmodule : uart_mctl_assertions
bind uart_mctl uart_mctl_assertions chk_u (.clk_i, .srst_i, .ce_i,
  .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o,
  .hresp_o, .tx_serial_i, .soft_reset_o, .irq_o, .trig_level_o,
  .modem_o, .txd_o, .txd_oe_n_o, .rts_n_o, .rts_oe_n_o, .dtr_n_o,
  .dtr_oe_n_o);

// *** tb/uart_far_station.sv ***
`timescale 1ns/100ps
module uart_far_station (
  // Clock
  input  wire logic       clk_i,
  // Wanted levels {rxd, cts_n, dsr_n, ri_n, dcd_n}
  input  wire logic [4:0] cmd_i,
  // Lines towards the port
  output logic      [4:0] pins_o
);
  // The far station reacts one clock late, like a real remote would
  initial pins_o = 5'h1F;
  always @(posedge clk_i) pins_o <= cmd_i;
endmodule : uart_far_station

// *** tb/uart_modem_and_interrupt_control_tb.sv ***
`timescale 1ns/100ps
module uart_modem_and_interrupt_control_tb;
  import uart_mctl_pkg::*;
  // ****************************************
  // Signals and model
  // ****************************************
  logic        clk_i, srst_i = 1'b1, ce_i = 1'b1, hsel_i = 1'b0;
  logic [11:0] haddr_i = 12'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0, tx_serial_i = 1'b1, tx_active_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0, hrdata_o;
  logic [3:0]  rx_count_i = 4'h0, trig_level_o;
  irq_src_s    src_i = 3'h0;
  logic        msr_clear_i = 1'b0, hreadyout_o, hresp_o, rx_serial_o;
  logic        tx_start_ok_o, modem_chg_o, soft_reset_o, irq_o, txd_o;
  logic        txd_oe_n_o, rts_n_o, rts_oe_n_o, dtr_n_o, dtr_oe_n_o;
  modem_st_s   modem_o;
  logic        nm_rts_n, nm_dtr_n, nm_rts_oe_n, nm_dtr_oe_n;
  modem_st_s   nm_modem;
  logic [4:0]  far_q = 5'h1F, far_w;
  logic [7:0]  mc_m = 8'h0, ie_m = 8'h0;
  logic [1:0]  tg_m = 2'h0;
  logic        hold_m = 1'b0;
  int          failures = 0, comparisons = 0, cyc = 0, k, x;
  int          tbl[4] = '{1, 2, 4, 7};
  int          cn[6] = '{0, 3, 4, 2, 0, 7};
  logic [15:0] cfg[10] = '{16'h0370, 16'h0160, 16'h0250, 16'h1F70,
    16'h4050, 16'h8070, 16'h0807, 16'h0806, 16'h0C05, 16'h0003};

  uart_mctl dut_u (.clk_i, .srst_i, .ce_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .tx_serial_i, .tx_active_i,
    .rx_count_i, .src_i, .msr_clear_i, .rx_serial_o, .tx_start_ok_o,
    .modem_o, .modem_chg_o, .trig_level_o, .soft_reset_o, .irq_o,
    .rxd_i(far_w[4]), .cts_n_i(far_w[3]), .dsr_n_i(far_w[2]),
    .ri_n_i(far_w[1]), .dcd_n_i(far_w[0]), .txd_o, .txd_oe_n_o,
    .rts_n_o, .rts_oe_n_o, .dtr_n_o, .dtr_oe_n_o);
  uart_far_station far_u (.clk_i, .cmd_i(far_q), .pins_o(far_w));
  // A port without modem support sees the same traffic; its modem side
  // must stay idle whatever software writes
  uart_mctl #(.MODEM_EN(1'b0)) nm_u (.clk_i, .srst_i, .ce_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o(), .hreadyout_o(), .hresp_o(),
    .tx_serial_i, .tx_active_i, .rx_count_i, .src_i, .msr_clear_i,
    .rx_serial_o(), .tx_start_ok_o(), .modem_o(nm_modem),
    .modem_chg_o(), .trig_level_o(), .soft_reset_o(), .irq_o(),
    .rxd_i(far_w[4]), .cts_n_i(far_w[3]), .dsr_n_i(far_w[2]),
    .ri_n_i(far_w[1]), .dcd_n_i(far_w[0]), .txd_o(), .txd_oe_n_o(),
    .rts_n_o(nm_rts_n), .rts_oe_n_o(nm_rts_oe_n), .dtr_n_o(nm_dtr_n),
    .dtr_oe_n_o(nm_dtr_oe_n));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      end_of_test();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("FAIL t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    if (a == 12'h000) mc_m = d;
    if (a == 12'h004) ie_m = d & IE_STORE_BITS;
    if (a == 12'h008) tg_m = d[7:6];
    if (a == 12'h004 && d[7])
    begin
      {mc_m, ie_m, tg_m, hold_m} = '0;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h0, r);
    chk(r, e);
  endtask : rd
  // Loopback reroutes modem lines and idles every driven pin
  task automatic pins();
    logic       lp;
    logic       ra;
    logic [3:0] m;
    logic [5:0] ps;
    logic [5:0] pe;
    logic [6:0] cs;
    logic [6:0] cx;
    logic [7:0] ns;
    repeat (3) @(posedge clk_i);
    lp = mc_m[4];
    ra = mc_m[1] & ~(mc_m[5] & hold_m);
    m = lp ? {ra, mc_m[0], mc_m[2], mc_m[3]} : ~far_q[3:0];
    ps = {txd_oe_n_o, rts_oe_n_o, dtr_oe_n_o, txd_o, rts_n_o, dtr_n_o};
    pe = {lp | ~ie_m[6], lp | ~ie_m[5], lp | ~ie_m[4], lp | tx_serial_i,
          lp | ~ra, lp | (mc_m[6] ? tx_active_i : ~mc_m[0])};
    cs = {irq_o, tx_start_ok_o, modem_o, rx_serial_o};
    cx = {mc_m[3] & |(ie_m[2:0] & src_i), ~mc_m[5] | m[3], m,
          lp ? tx_serial_i : (mc_m[7] & tx_active_i) | far_q[4]};
    ns = {nm_rts_n, nm_dtr_n, nm_rts_oe_n, nm_dtr_oe_n, nm_modem};
    chk(ps, pe);
    chk(cs, cx);
    chk(ns, 8'hF0);
  endtask : pins
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    x = $urandom(32'h632E);
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h00C, 32'h40);
    wr(12'h010, 8'hFF);
    rd(12'h010, 32'h0);
    pins();
    for (k = 0; k < 6; k++)
    begin
      wr(12'h000, 8'($urandom));
      wr(12'h004, 8'($urandom));
      rd(12'h000, {24'h0, mc_m});
      rd(12'h004, {24'h0, ie_m});
    end
    foreach (cfg[i])
    begin
      wr(12'h000, cfg[i][15:8]);
      wr(12'h004, cfg[i][7:0]);
      {far_q, tx_active_i, tx_serial_i, src_i} <= 10'($urandom);
      pins();
    end
    for (k = 0; k < 4; k++)
    begin
      wr(12'h008, 8'(k << 6));
      repeat (2) @(posedge clk_i);
      chk(trig_level_o, 32'(tbl[k]));
      rd(12'h008, {24'h0, tg_m, 6'h0});
    end
    wr(12'h008, 8'h80);
    wr(12'h000, 8'h22);
    wr(12'h004, 8'h70);
    foreach (cn[i])
    begin
      rx_count_i <= 4'(cn[i]);
      far_q[3] <= i[0];
      if (cn[i] >= 4) hold_m = 1'b1;
      else if (cn[i] == 0) hold_m = 1'b0;
      pins();
    end
    wr(12'h000, 8'h28);
    wr(12'h004, 8'h08);
    repeat (3) @(posedge clk_i);
    msr_clear_i <= 1'b1;
    @(posedge clk_i);
    msr_clear_i <= 1'b0;
    far_q[3] <= ~far_q[3];
    pins();
    chk({modem_chg_o, irq_o}, 32'h0);
    far_q[2] <= ~far_q[2];
    // Pin, flag and request each take one registered step
    repeat (4) @(posedge clk_i);
    chk({modem_chg_o, irq_o}, 32'h3);
    ce_i <= 1'b0;
    far_q <= ~far_q;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    wr(12'h004, 8'hF0);
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0);
    pins();
    end_of_test();
  end
endmodule : uart_modem_and_interrupt_control_tb
